/* core/gpio_debounce_data_regs_defs.vh */
// Address map, field layout, reset values and timing of the pin block.
`ifndef GPIO_DEBOUNCE_DATA_REGS_DEFS_VH
`define GPIO_DEBOUNCE_DATA_REGS_DEFS_VH

// Byte addresses of the register words (low 12 address bits).
`define ADDR_DIRECTION_LO 12'h62C
`define ADDR_DIRECTION_HI 12'h630
`define ADDR_FILTER_ENABLE 12'h638
`define ADDR_LEVEL_LO 12'h63C
`define ADDR_LEVEL_HI 12'h640
`define ADDR_DRIVE_LO 12'h644
`define ADDR_DRIVE_HI 12'h648

// Used bit masks, writable except the level words; every other bit is reserved and reads zero.
`define MASK_DIRECTION 32'h24924924
`define MASK_FILTER_ENABLE 32'h000FFFFF
`define MASK_LEVEL_LO 32'h00000FFF
`define MASK_LEVEL_HI 32'h000000FF
`define MASK_DRIVE_LO 32'h00000FFF
`define MASK_DRIVE_HI 32'h000000FF

// Reset values of the stored registers.
`define RESET_DIRECTION 32'h00000000
`define RESET_FILTER_ENABLE 32'h00000000
`define RESET_DRIVE 32'h00000000

// Pin grouping and direction field layout.
`define PIN_COUNT 20
`define LOW_GROUP_PINS 12
`define DIR_PINS_PER_WORD 10
`define DIR_FIRST_BIT 2
`define DIR_STRIDE 3

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Debounce time and core clock period, both in nanoseconds.
`define DEBOUNCE_TIME_NS 1300000
`define CLK_PERIOD_NS 25
// Quotient of the two times above, kept at the counter's own width so the
// parameter default takes it without losing bits.
`define DEBOUNCE_CYCLES 16'hCB20
`define DEBOUNCE_COUNT_WIDTH 16

`endif

/* core/gpio_debounce_data_regs.v */
// Twenty-pin general-purpose block with debounce and an AXI4-Lite slave.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gpio_debounce_data_regs_defs.vh"

module gpio_debounce_data_regs #(
	// Debounce length in core clocks; shorten for simulation.
	parameter [15:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
)
(
	input wire aclk,
	input wire aresetn,
	input wire port_zero_select,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [19:0] pin_in,
	output wire [19:0] pin_out,
	output wire [19:0] pin_oe
);

	// Stored direction words; only the direction bit positions are kept.
	reg [31:0] direction_lo;
	reg [31:0] direction_hi;
	// Per-pin debounce enables.
	reg [31:0] input_filter_enable;
	// Output values for the low and the high pin group.
	reg [31:0] drive_value_low_group;
	reg [31:0] drive_value_high_group;

	// Held write address and data while the partner channel is pending.
	reg aw_held;
	reg [11:0] aw_addr;
	reg w_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	// One bit per pin: set means the pin is an output.
	wire [19:0] pin_is_output;
	// Level of each pin after synchronising and optional filtering.
	wire [19:0] pin_level;
	// Level word seen by software, zero for output pins.
	wire [19:0] pin_level_seen;

	// Readback words built from pin state.
	wire [31:0] pin_level_low_group;
	wire [31:0] pin_level_high_group;

	// Combinational read decode results.
	reg [31:0] read_word;
	reg read_hit;

	// True when an address names one of this block's words.
	function is_mapped;
		input [11:0] addr;
		begin
			case (addr)
				`ADDR_DIRECTION_LO, `ADDR_DIRECTION_HI,
				`ADDR_FILTER_ENABLE, `ADDR_LEVEL_LO,
				`ADDR_LEVEL_HI, `ADDR_DRIVE_LO,
				`ADDR_DRIVE_HI:
					is_mapped = 1'b1;
				default:
					is_mapped = 1'b0;
			endcase
		end
	endfunction

	// Merges write data into an old word under the byte strobes and mask.
	function [31:0] merge_bytes;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0] strb;
		input [31:0] mask;
		integer b;
		reg [31:0] lane;
		begin
			lane = 32'h00000000;
			for (b = 0; b < 4; b = b + 1)
				lane[b*8 +: 8] = {8{strb[b]}};
			merge_bytes = ((new_word & lane) | (old_word & ~lane)) & mask;
		end
	endfunction

	// Handshakes may be combinational: ready while nothing is pending.
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// Per-pin logic: direction pick, synchroniser, debounce and drive.
	genvar i;
	generate
		for (i = 0; i < `PIN_COUNT; i = i + 1)
		begin : g_pin
			reg sync_first;
			reg sync_second;
			reg filtered;
			reg [`DEBOUNCE_COUNT_WIDTH-1:0] stable_count;
			wire filter_active;

			if (i < `DIR_PINS_PER_WORD)
			begin : g_lo
				assign pin_is_output[i] =
					direction_lo[`DIR_FIRST_BIT + `DIR_STRIDE*i];
			end
			else
			begin : g_hi
				assign pin_is_output[i] = direction_hi[`DIR_FIRST_BIT +
					`DIR_STRIDE*(i - `DIR_PINS_PER_WORD)];
			end

			assign filter_active = input_filter_enable[i] &
				~pin_is_output[i];

			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					sync_first <= 1'b0;
					sync_second <= 1'b0;
				end
				else
				begin
					sync_first <= pin_in[i];
					sync_second <= sync_first;
				end
			end

			// The count restarts whenever the input matches the filtered level again, so a
			// bouncing pin never reaches the end of the count.
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					filtered <= 1'b0;
					stable_count <= 16'h0000;
				end
				else if (!filter_active)
				begin
					// Tracking while idle avoids a glitch on enable.
					filtered <= sync_second;
					stable_count <= 16'h0000;
				end
				else if (sync_second == filtered)
				begin
					stable_count <= 16'h0000;
				end
				else if (stable_count >= DEBOUNCE_CYCLES - 16'h0001)
				begin
					filtered <= sync_second;
					stable_count <= 16'h0000;
				end
				else
				begin
					stable_count <= stable_count + 16'h0001;
				end
			end

			assign pin_level[i] = filter_active ? filtered : sync_second;

			assign pin_level_seen[i] = pin_level[i] & ~pin_is_output[i];

			assign pin_oe[i] = pin_is_output[i];

			if (i < `LOW_GROUP_PINS)
			begin : g_drive_lo
				assign pin_out[i] = drive_value_low_group[i];
			end
			else
			begin : g_drive_hi
				assign pin_out[i] =
					drive_value_high_group[i - `LOW_GROUP_PINS];
			end
		end
	endgenerate

	assign pin_level_low_group = {20'h00000,
		pin_level_seen[`LOW_GROUP_PINS-1:0]};
	assign pin_level_high_group = {24'h000000,
		pin_level_seen[`PIN_COUNT-1:`LOW_GROUP_PINS]};

	// Read decode; unmapped addresses read zero.
	always @*
	begin
		read_hit = is_mapped(s_axi_araddr) & port_zero_select;
		case (s_axi_araddr)
			`ADDR_DIRECTION_LO:
				read_word = direction_lo;
			`ADDR_DIRECTION_HI:
				read_word = direction_hi;
			`ADDR_FILTER_ENABLE:
				read_word = input_filter_enable;
			`ADDR_LEVEL_LO:
				read_word = pin_level_low_group;
			`ADDR_LEVEL_HI:
				read_word = pin_level_high_group;
			`ADDR_DRIVE_LO:
				read_word = drive_value_low_group;
			`ADDR_DRIVE_HI:
				read_word = drive_value_high_group;
			default:
				read_word = 32'h00000000;
		endcase
		if (!read_hit)
			read_word = 32'h00000000;
	end

	// Read channel: one read at a time, data captured at the address edge.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			// The data stays put until the master takes it.
			s_axi_rvalid <= 1'b0;
		end
	end

	// Write address and data are caught separately, in either order.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (aw_held && w_held)
		begin
			// Both halves are in; the write happens this edge.
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Register update and write response.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			direction_lo <= `RESET_DIRECTION;
			direction_hi <= `RESET_DIRECTION;
			input_filter_enable <= `RESET_FILTER_ENABLE;
			drive_value_low_group <= `RESET_DRIVE;
			drive_value_high_group <= `RESET_DRIVE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else if (aw_held && w_held)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (is_mapped(aw_addr) && port_zero_select) ?
				`RESP_OKAY : `RESP_SLVERR;
			if (port_zero_select)
			begin
				case (aw_addr)
					`ADDR_DIRECTION_LO:
						direction_lo <= merge_bytes(direction_lo,
							w_data, w_strb, `MASK_DIRECTION);
					`ADDR_DIRECTION_HI:
						direction_hi <= merge_bytes(direction_hi,
							w_data, w_strb, `MASK_DIRECTION);
					`ADDR_FILTER_ENABLE:
						input_filter_enable <= merge_bytes(
							input_filter_enable, w_data, w_strb,
							`MASK_FILTER_ENABLE);
					`ADDR_DRIVE_LO:
						drive_value_low_group <= merge_bytes(
							drive_value_low_group, w_data, w_strb,
							`MASK_DRIVE_LO);
					`ADDR_DRIVE_HI:
						drive_value_high_group <= merge_bytes(
							drive_value_high_group, w_data, w_strb,
							`MASK_DRIVE_HI);
					default:
						// Level words and holes keep their state.
						drive_value_low_group <= drive_value_low_group;
				endcase
			end
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

endmodule // gpio_debounce_data_regs

/* bench/gpio_debounce_data_regs_asserts.sv */
// Bus and pin property checks for the twenty-pin block.
`timescale 1ns/1ps
module gpio_debounce_data_regs_asserts (
	input wire aclk,
	input wire aresetn,
	input wire port_zero_select,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire [19:0] pin_out,
	input wire [19:0] pin_oe
);
	// Address of the read in flight, kept so answers can be judged.
	reg [11:0] rd_addr;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready;

	// Captured at the take edge; the answer leaves at that same edge.
	always @(posedge aclk)
	begin
		if (rd_take)
			rd_addr <= s_axi_araddr;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	rd_answer_a:
	assert property (rd_take |=> s_axi_rvalid)
		else $error("read taken but not answered");
	absent_read_a:
	assert property (rd_take && !port_zero_select
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("absent block answered a read");
	low_level_a:
	assert property ($rose(s_axi_rvalid) && rd_addr == 12'h63C
		|-> (s_axi_rdata[11:0] & $past(pin_oe[11:0])) == 12'h0)
		else $error("output pin level not zero in low word");
	low_reserved_a:
	assert property ($rose(s_axi_rvalid) && rd_addr == 12'h63C
		|-> s_axi_rdata[31:12] == 20'h0)
		else $error("low level word reserved bits set");
	high_level_a:
	assert property ($rose(s_axi_rvalid) && rd_addr == 12'h640
		|-> s_axi_rdata[31:8] == 24'h0
		&& (s_axi_rdata[7:0] & $past(pin_oe[19:12])) == 8'h0)
		else $error("high level word wrong for outputs or reserved");
	enable_reserved_a:
	assert property ($rose(s_axi_rvalid) && rd_addr == 12'h638
		&& s_axi_rresp == 2'h0 |-> s_axi_rdata[31:20] == 12'h0)
		else $error("filter enable reserved bits set");
	oe_by_write_a:
	assert property (!$stable(pin_oe) |-> $rose(s_axi_bvalid))
		else $error("pin direction changed without a write");
	out_by_write_a:
	assert property (!$stable(pin_out) |-> $rose(s_axi_bvalid))
		else $error("pin drive changed without a write");
	write_answer_a:
	assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write taken but not answered");
endmodule // gpio_debounce_data_regs_asserts

bind gpio_debounce_data_regs gpio_debounce_data_regs_asserts
	gpio_debounce_data_regs_asserts_inst (
	.aclk(aclk),
	.aresetn(aresetn),
	.port_zero_select(port_zero_select),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.pin_out(pin_out),
	.pin_oe(pin_oe)
);

/* bench/pin_board_model.sv */
// Board-side model of the twenty pins, with optional contact chatter.
`timescale 1ns/1ps
module pin_board_model (
	input wire aclk,
	input wire [19:0] pin_out,
	input wire [19:0] pin_oe,
	input wire [19:0] board_level,
	input wire [19:0] bounce_mask,
	output wire [19:0] pin_in
);
	// Flips every clock, so a chattering pin is never quiet long enough.
	reg chatter = 1'h0;

	// Free-running toggle for the chatter pattern.
	always @(posedge aclk)
	begin
		chatter <= ~chatter;
	end

	// output pins driven
	// A pin set as output carries the block's own value back in.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe
		& (board_level ^ (bounce_mask & {20{chatter}})));
endmodule // pin_board_model

/* bench/gpio_debounce_data_regs_test.sv */
// Self-checking bench for the pin block over its register bus.
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		total_checks++; \
		if ((a) !== (b)) \
		begin \
			fails++; \
			$display("ERROR at %0t got %h expected %h", $time, a, b); \
		end \
	end
module gpio_debounce_data_regs_test;
	reg aclk = 1'h0;
	reg aresetn = 1'h0;
	reg port_zero_select = 1'h1;
	reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hF;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [19:0] pin_in, pin_out, pin_oe;
	reg [19:0] board_level = 20'h0, bounce_mask = 20'h0;
	int fails = 0, total_checks = 0, cycles = 0;

	// Debounce shortened to 8 clocks to keep the run brief.
	gpio_debounce_data_regs #(.DEBOUNCE_CYCLES(16'h0008))
		gpio_debounce_data_regs_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.port_zero_select(port_zero_select),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe));
	pin_board_model pin_board_model_inst (.aclk(aclk), .pin_out(pin_out),
		.pin_oe(pin_oe), .board_level(board_level),
		.bounce_mask(bounce_mask), .pin_in(pin_in));

	// 40 MHz core clock.
	always #12.5 aclk = ~aclk;

	// Prints the verdict and ends the run.
	task summarize;
	begin
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	// A hang is cut short well beyond the expected run length.
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			fails++;
			summarize;
		end
	end

	// Write; both halves offered together, each dropped when taken.
	task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
		reg ad;
		reg wd;
	begin
		ad = 1'h0;
		wd = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (!ad && s_axi_awready)
			begin
				ad = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (!wd && s_axi_wready)
			begin
				wd = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		while (!s_axi_bvalid)
			@(posedge aclk);
		`CHK(s_axi_bresp, e)
		s_axi_bready <= 1'h0;
	end
	endtask

	// Read and compare response code and data together.
	task rd(input [11:0] a, input [31:0] e, input [1:0] er);
	begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		while (!s_axi_arready)
			@(posedge aclk);
		s_axi_arvalid <= 1'h0;
		@(posedge aclk);
		while (!s_axi_rvalid)
			@(posedge aclk);
		`CHK({s_axi_rresp, s_axi_rdata}, {er, e})
		s_axi_rready <= 1'h0;
	end
	endtask

	// Main sequence; expectations come from the register layout.
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rd(12'h638, 32'h0, 2'h0);
		rd(12'h63C, 32'h0, 2'h0);
		rd(12'h640, 32'h0, 2'h0);
		rd(12'h644, 32'h0, 2'h0);
		rd(12'h700, 32'h0, 2'h2);
		wr(12'h638, 32'hFFFFFFFF, 4'hF, 2'h0);
		rd(12'h638, 32'h000FFFFF, 2'h0);
		wr(12'h638, 32'h0, 4'h1, 2'h0);
		rd(12'h638, 32'h000FFF00, 2'h0);
		wr(12'h638, 32'h0, 4'hF, 2'h0);
		board_level <= 20'hA5A5A;
		repeat (4) @(posedge aclk);
		rd(12'h63C, 32'h00000A5A, 2'h0);
		rd(12'h640, 32'h000000A5, 2'h0);
		wr(12'h63C, 32'hFFFFFFFF, 4'hF, 2'h0);
		rd(12'h63C, 32'h00000A5A, 2'h0);
		wr(12'h644, 32'hFFFFF555, 4'hF, 2'h0);
		rd(12'h644, 32'h00000555, 2'h0);
		wr(12'h648, 32'hFFFFFFA5, 4'hF, 2'h0);
		rd(12'h648, 32'h000000A5, 2'h0);
		`CHK(pin_out[19:12], 8'hA5)
		wr(12'h62C, 32'hFFFFFFFF, 4'hF, 2'h0);
		`CHK(pin_oe, 20'h003FF)
		`CHK(pin_out[11:0], 12'h555)
		rd(12'h62C, 32'h24924924, 2'h0);
		rd(12'h63C, 32'h00000800, 2'h0);
		wr(12'h630, 32'h00000024, 4'hF, 2'h0);
		`CHK(pin_oe, 20'h00FFF)
		rd(12'h63C, 32'h0, 2'h0);
		rd(12'h640, 32'h000000A5, 2'h0);
		wr(12'h62C, 32'h0, 4'hF, 2'h0);
		wr(12'h630, 32'h0, 4'hF, 2'h0);
		wr(12'h638, 32'h00000001, 4'hF, 2'h0);
		board_level <= 20'h00003;
		bounce_mask <= 20'h00001;
		repeat (30) @(posedge aclk);
		rd(12'h63C, 32'h00000002, 2'h0);
		bounce_mask <= 20'h0;
		rd(12'h63C, 32'h00000002, 2'h0);
		repeat (12) @(posedge aclk);
		rd(12'h63C, 32'h00000003, 2'h0);
		port_zero_select <= 1'h0;
		wr(12'h644, 32'h0, 4'hF, 2'h2);
		rd(12'h644, 32'h0, 2'h2);
		port_zero_select <= 1'h1;
		rd(12'h644, 32'h00000555, 2'h0);
		aresetn <= 1'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		`CHK(pin_out, 20'h0)
		rd(12'h638, 32'h0, 2'h0);
		summarize;
	end
endmodule // gpio_debounce_data_regs_test
